// [logic/wdt_halt_ctrl.sv]
// watchdog timer with halt and stop control, registers on an ahb-lite slave
module wdt_halt_ctrl #(
    parameter logic [23:0] WDT_P1 = wdt_halt_pkg::PER_C1,
    parameter logic [23:0] WDT_P2 = wdt_halt_pkg::PER_C2,
    parameter logic [23:0] WDT_P3 = wdt_halt_pkg::PER_C3,
    parameter logic [23:0] WDT_P4 = wdt_halt_pkg::PER_C4,
    parameter logic [23:0] WDT_P5 = wdt_halt_pkg::PER_C5,
    parameter logic [23:0] WDT_P6 = wdt_halt_pkg::PER_C6,
    parameter logic [23:0] WDT_P7 = wdt_halt_pkg::PER_C7
) (
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic INSTR_DONE_I,
    input wire logic EXEC_HALT_I,
    input wire logic EXEC_STOP_I,
    input wire logic WDT_KICK_I,
    input wire logic IRQ_PEND_I,
    output logic CPU_CLK_EN_O,
    output logic WAKE_O,
    output logic WDT_RST_O,
    output logic [15:0] RESTART_ADDR_O,
    output logic IRQ_O
);

    logic wr_wait_ff;
    logic [7:0] waddr_ff;
    logic [31:0] rdata_ff;
    logic [4:0] ctrl_ff;
    logic [4:0] nxt_ctrl;
    logic first_open_ff;
    logic [3:0] status_ff;
    logic [3:0] mask_ff;
    logic [3:0] nxt_status;
    logic [22:0] count_ff;
    logic [22:0] nxt_count;
    logic wdt_rst_ff;
    logic wake_ff;
    logic cpu_clk_en_ff;
    wdt_halt_pkg::pwr_state_t state_ff;
    wdt_halt_pkg::pwr_state_t nxt_state;
    logic halt_ev;
    logic stop_ev;
    logic wake_ev;
    logic [23:0] per_tab [8];

    // bus decode; hsize is not checked, every access is a word
    wire addr_ok = HSEL_I & HTRANS_I[1] & HREADY_I;
    wire rd_acc = addr_ok & ~HWRITE_I;
    wire wr_acc = addr_ok & HWRITE_I;
    wire [7:0] raddr = HADDR_I[7:0];
    wire ctl_wr = wr_wait_ff & (waddr_ff == wdt_halt_pkg::ADDR_CTRL);
    wire msk_wr = wr_wait_ff & (waddr_ff == wdt_halt_pkg::ADDR_MASK);
    wire st_rd = rd_acc & (raddr == wdt_halt_pkg::ADDR_STATUS);
    wire [31:0] rd_mux =
        (raddr == wdt_halt_pkg::ADDR_CTRL) ? {24'h0, ctrl_ff, 3'h0} :
        (raddr == wdt_halt_pkg::ADDR_STATUS) ? {28'h0, status_ff} :
        (raddr == wdt_halt_pkg::ADDR_MASK) ? {28'h0, mask_ff} :
        (raddr == wdt_halt_pkg::ADDR_COUNT) ? {9'h0, count_ff} :
        (raddr == wdt_halt_pkg::ADDR_STATE) ? {29'h0, first_open_ff, state_ff} :
        32'h0;

    // watchdog period selection and counting
    assign per_tab[0] = 24'h0;
    assign per_tab[1] = WDT_P1;
    assign per_tab[2] = WDT_P2;
    assign per_tab[3] = WDT_P3;
    assign per_tab[4] = WDT_P4;
    assign per_tab[5] = WDT_P5;
    assign per_tab[6] = WDT_P6;
    assign per_tab[7] = WDT_P7;
    wire [2:0] sel = ctrl_ff[wdt_halt_pkg::CTL_SEL_HI:wdt_halt_pkg::CTL_SEL_LO];
    wire [23:0] per_m1 = per_tab[sel] - 24'h1;
    wire halted = state_ff == wdt_halt_pkg::ST_HALT;
    wire counting = (sel != 3'h0)
        & (state_ff != wdt_halt_pkg::ST_STOP)
        & ~(halted & ~ctrl_ff[wdt_halt_pkg::CTL_HWE]);
    // >= so that shortening the period mid-count still fires
    wire expire = counting & ~WDT_KICK_I & ({1'b0, count_ff} >= per_m1);

    always_comb begin
        nxt_count = count_ff;
        if (expire | WDT_KICK_I) begin
            nxt_count = 23'h0;
        end else if (counting) begin
            nxt_count = count_ff + 23'h1;
        end
    end

    // control byte; time-out restores reset values and reopens the window
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (expire) begin
            nxt_ctrl = wdt_halt_pkg::CTRL_RST;
        end else if (ctl_wr & first_open_ff) begin
            nxt_ctrl = HWDATA_I[7:3];
        end
    end

    // power state machine
    always_comb begin
        nxt_state = state_ff;
        halt_ev = 1'b0;
        stop_ev = 1'b0;
        wake_ev = 1'b0;
        if (expire) begin
            nxt_state = wdt_halt_pkg::ST_RUN;
        end else begin
            case (state_ff)
                wdt_halt_pkg::ST_RUN: begin
                    if (EXEC_HALT_I) begin
                        nxt_state = wdt_halt_pkg::ST_HALT;
                        halt_ev = 1'b1;
                    end else if (EXEC_STOP_I & ~ctrl_ff[wdt_halt_pkg::CTL_INH]) begin
                        nxt_state = wdt_halt_pkg::ST_STOP;
                        stop_ev = 1'b1;
                    end
                end
                wdt_halt_pkg::ST_HALT, wdt_halt_pkg::ST_STOP: begin
                    if (IRQ_PEND_I) begin
                        nxt_state = wdt_halt_pkg::ST_RUN;
                        wake_ev = 1'b1;
                    end
                end
                default: begin
                    nxt_state = wdt_halt_pkg::ST_RUN;
                end
            endcase
        end
    end

    // sticky events; a set in the clearing read's cycle survives
    wire [3:0] ev = {wake_ev, stop_ev, halt_ev, expire};
    assign nxt_status = (status_ff & ~{4{st_rd}}) | ev;

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wr_wait_ff <= 1'b0;
            waddr_ff <= 8'h0;
            rdata_ff <= 32'h0;
            mask_ff <= 4'h0;
            status_ff <= 4'h0;
        end else begin
            wr_wait_ff <= wr_acc;
            waddr_ff <= wr_acc ? raddr : waddr_ff;
            rdata_ff <= rd_acc ? rd_mux : rdata_ff;
            mask_ff <= msk_wr ? HWDATA_I[3:0] : mask_ff;
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_ff <= wdt_halt_pkg::CTRL_RST;
            first_open_ff <= 1'b1;
            count_ff <= 23'h0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            // window closes when the first instruction retires
            first_open_ff <= expire | (first_open_ff & ~INSTR_DONE_I);
            count_ff <= nxt_count;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_ff <= wdt_halt_pkg::ST_RUN;
            cpu_clk_en_ff <= 1'b1;
            wake_ff <= 1'b0;
            wdt_rst_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cpu_clk_en_ff <= nxt_state == wdt_halt_pkg::ST_RUN;
            wake_ff <= wake_ev;
            wdt_rst_ff <= expire;
        end
    end

    // writes take one wait state so a following read sees the new value
    assign HREADYOUT_O = ~wr_wait_ff;
    assign HRESP_O = 1'b0;
    assign HRDATA_O = rdata_ff;
    assign CPU_CLK_EN_O = cpu_clk_en_ff;
    // the core's saved return address already points past the halt
    assign WAKE_O = wake_ff;
    assign WDT_RST_O = wdt_rst_ff;
    assign RESTART_ADDR_O = wdt_halt_pkg::RESTART_ADDR;
    assign IRQ_O = |(status_ff & mask_ff);

    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    property p_open_write;
        ctl_wr & first_open_ff & ~expire |=> ctrl_ff == $past(HWDATA_I[7:3]);
    endproperty
    a_open_write: assert property (p_open_write) else $error("open write lost");

    property p_locked;
        ctl_wr & ~first_open_ff & ~expire |=> $stable(ctrl_ff);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write took");

    property p_rst_vals;
        WDT_RST_O |-> ctrl_ff == wdt_halt_pkg::CTRL_RST && first_open_ff;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad control after timeout");

    property p_expire;
        expire |=> WDT_RST_O ##1 !WDT_RST_O;
    endproperty
    a_expire: assert property (p_expire) else $error("reset pulse wrong");

    property p_off;
        sel == 3'h0 |=> !WDT_RST_O;
    endproperty
    a_off: assert property (p_off) else $error("disabled watchdog fired");

    property p_count;
        counting & ~expire & ~WDT_KICK_I |=> count_ff == 23'($past(count_ff) + 23'h1);
    endproperty
    a_count: assert property (p_count) else $error("count did not step");

    property p_halt_hold;
        halted & ~ctrl_ff[wdt_halt_pkg::CTL_HWE] & ~WDT_KICK_I |=> $stable(count_ff);
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("count ran in halt");

    property p_stop_nop;
        state_ff == wdt_halt_pkg::ST_RUN & EXEC_STOP_I & ~EXEC_HALT_I
            & ctrl_ff[wdt_halt_pkg::CTL_INH] |=> CPU_CLK_EN_O;
    endproperty
    a_stop_nop: assert property (p_stop_nop) else $error("inhibited stop entered");

    property p_stop_in;
        state_ff == wdt_halt_pkg::ST_RUN & EXEC_STOP_I & ~EXEC_HALT_I & ~expire
            & ~ctrl_ff[wdt_halt_pkg::CTL_INH] |=> state_ff == wdt_halt_pkg::ST_STOP;
    endproperty
    a_stop_in: assert property (p_stop_in) else $error("stop not entered");

    property p_halt_in;
        state_ff == wdt_halt_pkg::ST_RUN & EXEC_HALT_I & ~expire |=> !CPU_CLK_EN_O && halted;
    endproperty
    a_halt_in: assert property (p_halt_in) else $error("halt not entered");

    property p_wake;
        halted & IRQ_PEND_I & ~expire |=> WAKE_O && CPU_CLK_EN_O ##1 !WAKE_O;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake from halt");

    property p_win_close;
        first_open_ff & INSTR_DONE_I & ~expire |=> !first_open_ff;
    endproperty
    a_win_close: assert property (p_win_close) else $error("window not closed");

    property p_win_shut;
        !first_open_ff & ~expire |=> !first_open_ff;
    endproperty
    a_win_shut: assert property (p_win_shut) else $error("window reopened");

    property p_kick;
        WDT_KICK_I |=> count_ff == 23'h0;
    endproperty
    a_kick: assert property (p_kick) else $error("kick did not clear count");

    property p_halt_clk;
        halted |-> !CPU_CLK_EN_O;
    endproperty
    a_halt_clk: assert property (p_halt_clk) else $error("cpu clock ran in halt");

    property p_run_clk;
        state_ff == wdt_halt_pkg::ST_RUN |-> CPU_CLK_EN_O;
    endproperty
    a_run_clk: assert property (p_run_clk) else $error("cpu clock off in run");

    property p_stop_hold;
        state_ff == wdt_halt_pkg::ST_STOP & ~WDT_KICK_I |=> $stable(count_ff);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("count ran in stop");

    property p_tmo_run;
        WDT_RST_O |-> state_ff == wdt_halt_pkg::ST_RUN && CPU_CLK_EN_O;
    endproperty
    a_tmo_run: assert property (p_tmo_run) else $error("time-out left core halted");

    property p_tmo_count;
        WDT_RST_O |-> count_ff == 23'h0;
    endproperty
    a_tmo_count: assert property (p_tmo_count) else $error("count not restarted");

    property p_no_early;
        counting & ({1'b0, count_ff} < per_m1) |=> !WDT_RST_O;
    endproperty
    a_no_early: assert property (p_no_early) else $error("early time-out");

    property p_tmo_flag;
        expire |=> status_ff[wdt_halt_pkg::EV_TIMEOUT];
    endproperty
    a_tmo_flag: assert property (p_tmo_flag) else $error("time-out flag lost");

    property p_halt_flag;
        state_ff == wdt_halt_pkg::ST_RUN & EXEC_HALT_I & ~expire
            |=> status_ff[wdt_halt_pkg::EV_HALT];
    endproperty
    a_halt_flag: assert property (p_halt_flag) else $error("halt flag lost");

    property p_wake_pulse;
        WAKE_O |=> !WAKE_O;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");

    c_halt_wake: cover property (halted & IRQ_PEND_I ##1 WAKE_O);
    c_open_write: cover property (ctl_wr & first_open_ff);
    c_stop: cover property (state_ff == wdt_halt_pkg::ST_STOP);
    c_timeout: cover property (WDT_RST_O);
    c_locked: cover property (ctl_wr & ~first_open_ff);
endmodule

// [logic/wdt_halt_pkg.sv]
// constants for the watchdog and power-down control block
package wdt_halt_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0C;
    localparam logic [7:0] ADDR_STATE = 8'h10;
    // control byte bits 7..3 are held as a 5-bit field
    localparam int CTL_LSB = 3;
    localparam int CTL_W = 5;
    localparam int CTL_HWE = 4;
    localparam int CTL_SEL_HI = 3;
    localparam int CTL_SEL_LO = 1;
    localparam int CTL_INH = 0;
    // halt watchdog on, period code 001, stop inhibited
    localparam logic [4:0] CTRL_RST = 5'h13;
    // event bits of status and mask
    localparam int EV_TIMEOUT = 0;
    localparam int EV_HALT = 1;
    localparam int EV_STOP = 2;
    localparam int EV_WAKE = 3;
    localparam int EV_W = 4;
    // watchdog periods in crystal cycles, codes 001..111
    localparam int CNT_W = 23;
    localparam logic [23:0] PER_C1 = 24'h010000;
    localparam logic [23:0] PER_C2 = 24'h020000;
    localparam logic [23:0] PER_C3 = 24'h040000;
    localparam logic [23:0] PER_C4 = 24'h080000;
    localparam logic [23:0] PER_C5 = 24'h100000;
    localparam logic [23:0] PER_C6 = 24'h200000;
    localparam logic [23:0] PER_C7 = 24'h800000;
    localparam logic [15:0] RESTART_ADDR = 16'h0020;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HALT = 2'b01,
        ST_STOP = 2'b11
    } pwr_state_t;
endpackage

// [verification/core_model.sv]
// processor core model that issues the control instructions
module core_model (
    input wire logic clk_i,
    input wire logic cpu_clk_en_i,
    output logic done_o,
    output logic halt_o,
    output logic stop_o,
    output logic kick_o,
    output logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] p = 4'h0;
    assign {kick_o, stop_o, halt_o, done_o} = p;
    initial irq_o = 1'b0;
    // 0 retire, 1 halt, 2 stop, 3 kick; pulse lasts one cycle, then one idle edge
    task automatic op(input int k);
        // a gated core retires nothing
        if (!(k == 0 && cpu_clk_en_i !== 1'b1)) begin
            p[k] <= 1'b1;
        end
        @(posedge clk_i);
        p <= 4'h0;
        @(posedge clk_i);
    endtask
    task automatic irq(input logic v);
        irq_o <= v;
    endtask
endmodule

// [verification/testbench.sv]
// self-checking bench for the watchdog and power-down control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // shortened periods keep the run brief
    localparam int P[8] = '{32'h0, 32'h8, 32'h10, 32'h20, 32'h40, 32'h80, 32'h100, 32'h400};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, hrd_q, d, seed = 32'h0000004D;
    logic hready, hresp, done, halt, stop, kick, irq, cpu_en, wake, wrst, irq_o;
    logic [15:0] raddr;
    int mismatches = 0;
    int tests_run = 0;
    int n;
    always #2.5 clk = ~clk;
    wdt_halt_ctrl #(.WDT_P1(24'(P[1])), .WDT_P2(24'(P[2])), .WDT_P3(24'(P[3])),
        .WDT_P4(24'(P[4])), .WDT_P5(24'(P[5])), .WDT_P6(24'(P[6])), .WDT_P7(24'(P[7])))
    wdt_halt_ctrl_i (.MCLK_I(clk), .ARST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .INSTR_DONE_I(done), .EXEC_HALT_I(halt), .EXEC_STOP_I(stop), .WDT_KICK_I(kick),
        .IRQ_PEND_I(irq), .CPU_CLK_EN_O(cpu_en), .WAKE_O(wake), .WDT_RST_O(wrst),
        .RESTART_ADDR_O(raddr), .IRQ_O(irq_o));
    core_model core_model_i (.clk_i(clk), .cpu_clk_en_i(cpu_en), .done_o(done),
        .halt_o(halt), .stop_o(stop), .kick_o(kick), .irq_o(irq));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // control byte as software writes it; low three bits stay zero
    function automatic logic [31:0] ctl(input logic hwe, input logic [2:0] c, input logic inh);
        return {24'h0, hwe, c, inh, 3'h0};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ready is looked at mid-cycle, then the following rising edge is the sampling edge
    task automatic rdy();
        @(negedge clk);
        while (hready !== 1'b1) @(negedge clk);
        hrd_q = hrdata;
        @(posedge clk);
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
        logic [31:0] r;
        // upper address bits are random, the slave decodes only the low byte
        r = rnd();
        hsel <= 1'b1;
        haddr <= {r[31:8], a};
        hsize <= 3'h2;
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= v;
        rdy();
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(hrd_q, exp);
    endtask
    task automatic reset();
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        // release between edges so no property attempt straddles it
        @(negedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    // edges until the time-out pulse, bounded by lim
    task automatic tmo(input int lim);
        n = 0;
        while (wrst !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
    endtask
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    initial begin
        reset();
        rdchk(wdt_halt_pkg::ADDR_CTRL, 32'h98);
        chk(raddr, 32'h20);
        for (int c = 1; c < 8; c++) begin
            core_model_i.op(3);
            xfer(1'b1, wdt_halt_pkg::ADDR_CTRL, ctl(1'b1, c[2:0], 1'b1));
            core_model_i.op(3);
            tmo(1200);
            chk(n, P[c] - 1);
        end
        core_model_i.op(3);
        xfer(1'b1, wdt_halt_pkg::ADDR_CTRL, ctl(1'b1, 3'h0, 1'b1));
        tmo(1200);
        chk(n, 1200);
        $display("period test done");
        xfer(1'b1, wdt_halt_pkg::ADDR_CTRL, ctl(1'b0, 3'h0, 1'b0));
        rdchk(wdt_halt_pkg::ADDR_CTRL, ctl(1'b0, 3'h0, 1'b0));
        core_model_i.op(0);
        xfer(1'b1, wdt_halt_pkg::ADDR_CTRL, ctl(1'b1, 3'h1, 1'b1));
        rdchk(wdt_halt_pkg::ADDR_CTRL, ctl(1'b0, 3'h0, 1'b0));
        core_model_i.op(2);
        chk(cpu_en, 1'b0);
        rdchk(wdt_halt_pkg::ADDR_STATE, 32'h3);
        core_model_i.irq(1'b1);
        @(posedge clk);
        #1;
        chk({cpu_en, wake}, 2'b11);
        @(posedge clk);
        core_model_i.irq(1'b0);
        d = rnd();
        rdchk({1'b1, d[4:0], 2'b0}, 32'h0);
        chk(hresp, 1'b0);
        $display("write lock and stop test done");
        reset();
        core_model_i.op(3);
        xfer(1'b1, wdt_halt_pkg::ADDR_CTRL, ctl(1'b0, 3'h3, 1'b1));
        d = rnd();
        xfer(1'b1, wdt_halt_pkg::ADDR_MASK, d);
        rdchk(wdt_halt_pkg::ADDR_MASK, {28'h0, d[3:0]});
        xfer(1'b1, wdt_halt_pkg::ADDR_MASK, 32'h2);
        core_model_i.op(0);
        core_model_i.op(1);
        chk(cpu_en, 1'b0);
        chk(irq_o, 1'b1);
        tmo(3 * P[3]);
        chk(n, 3 * P[3]);
        core_model_i.irq(1'b1);
        @(posedge clk);
        #1;
        chk({cpu_en, wake}, 2'b11);
        @(posedge clk);
        core_model_i.irq(1'b0);
        rdchk(wdt_halt_pkg::ADDR_STATUS, 32'hA);
        chk(irq_o, 1'b0);
        $display("halt without watchdog test done");
        reset();
        core_model_i.op(3);
        xfer(1'b1, wdt_halt_pkg::ADDR_CTRL, ctl(1'b1, 3'h3, 1'b1));
        core_model_i.op(0);
        core_model_i.op(2);
        chk(cpu_en, 1'b1);
        core_model_i.op(1);
        tmo(3 * P[3]);
        chk(n < P[3], 1'b1);
        chk(cpu_en, 1'b1);
        rdchk(wdt_halt_pkg::ADDR_CTRL, 32'h98);
        rdchk(wdt_halt_pkg::ADDR_STATUS, 32'h3);
        $display("halt with watchdog test done");
        summarize();
    end
endmodule
